// >>> plsc_pin_ctrl.sv
// per-pin driver, read-back and skip logic of one byte-wide port
// assumes pin levels already synchronous to clk; registered in the parent
`timescale 1ns/10ps
module plsc_pin_ctrl
  import plsc_pkg::*;
(
  input wire plsc_pkg::plsc_port_cfg_t cfg,
  input wire logic [7:0] present,
  input wire logic [7:0] pin_in,
  output plsc_pkg::plsc_pin_drv_t drv,
  output logic [7:0] rd_val,
  output logic [7:0] skip_out
);
  import plsc_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PLSC_W; i++) begin : g_pin
      // analog pins drop driver and receiver; open-drain never drives high
      assign drv.dout[i] = cfg.latch[i];
      assign drv.oe_n[i] = !(present[i] && cfg.inmode[i]
                             && (!cfg.latch[i] || cfg.outmode[i]));
      assign drv.ana[i] = present[i] && !cfg.inmode[i];
      // reads show the pin, not the latch, and zero for analog pins
      assign rd_val[i] = present[i] && cfg.inmode[i] && pin_in[i];
      // absent pins are always forced skipped here, but the parent's registered skip outputs are cleared by reset
      assign skip_out[i] = cfg.skip[i] || !present[i];
    end
  endgenerate
endmodule

// >>> plsc_pin_model.sv
// pin model: what the package pins show the block
// assumes outside sources hold ext levels wherever a pin is released
`timescale 1ns/10ps
module plsc_pin_model
  import plsc_pkg::*;
(
  input plsc_pkg::plsc_pin_drv_t port3_drv,
  input plsc_pkg::plsc_pin_drv_t port4_drv,
  input logic [7:0] ext3,
  input logic [7:0] ext4,
  output logic [7:0] port3_pin_in,
  output logic [7:0] port4_pin_in
);
  // released pins show the outside level, never the last driven one
  assign port3_pin_in = (port3_drv.dout & ~port3_drv.oe_n) | (ext3 & port3_drv.oe_n);
  assign port4_pin_in = (port4_drv.dout & ~port4_drv.oe_n) | (ext4 & port4_drv.oe_n);
endmodule

// >>> plsc_pkg.sv
// package for the port latch / skip / input-mode block
// assumes an 8-bit special-function register bus with byte addresses
package plsc_pkg;
  localparam int PLSC_W = 8;
  // register addresses
  localparam logic [7:0] PLSC_ADDR_PORT2_SKIP = 8'hd6;
  localparam logic [7:0] PLSC_ADDR_PORT3_LATCH = 8'hb0;
  localparam logic [7:0] PLSC_ADDR_PORT3_INMODE = 8'hf4;
  localparam logic [7:0] PLSC_ADDR_PORT3_SKIP = 8'hdf;
  localparam logic [7:0] PLSC_ADDR_PORT4_LATCH = 8'hc7;
  localparam logic [7:0] PLSC_ADDR_PORT4_INMODE = 8'hf5;
  localparam logic [7:0] PLSC_ADDR_PORT4_OUTMODE = 8'hae;
  // reset values
  localparam logic [7:0] PLSC_RST_LATCH = 8'hff;
  localparam logic [7:0] PLSC_RST_INMODE = 8'hff;
  localparam logic [7:0] PLSC_RST_OUTMODE = 8'h00;
  localparam logic [7:0] PLSC_RST_SKIP = 8'h00;
  localparam logic [7:0] PLSC_ZERO = 8'h00;
  // pins of the third port present in the small package
  localparam logic [7:0] PLSC_PORT3_SMALL_MASK = 8'h01;
  localparam logic [7:0] PLSC_ALL_MASK = 8'hff;

  // special-function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } plsc_sfr_req_t;

  // per-port configuration
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] inmode;
    logic [7:0] outmode;
    logic [7:0] skip;
  } plsc_port_cfg_t;

  // pin-side drive of one port
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
    logic [7:0] ana;
  } plsc_pin_drv_t;
endpackage

// >>> plsc_port_regs.sv
// latch, input-mode, output-mode and skip registers of ports two to four
// assumes a single-cycle sfr bus: write strobe with address, read data
// registered one cycle after the read strobe; pins synchronous to clk
//
// Notes on behaviour
// - a skip bit of 1 makes the crossbar pass over the pin, 0 leaves it usable.
// - the crossbar sees every port's skip bits and never uses a skipped pin.
// - a latch bit of 0 drives the pin low and 1 drives it high on a push-pull pin.
// - a latch bit of 1 on an open-drain pin leaves the pin floating.
// - port reads return 0 for every analog-configured pin.
// - port reads of a digital pin return the pin level, not the latch.
// - the fourth port exists only in the large package.
// - of the third port only bit 0 exists in the small package.
// - an input-mode bit of 0 makes the pin analog with driver and receiver off.
// - output-mode 1 is push-pull, 0 open-drain, ignored for analog pins.
`timescale 1ns/10ps
module plsc_port_regs
  import plsc_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire plsc_pkg::plsc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [7:0] port3_pin_in,
  input wire logic [7:0] port4_pin_in,
  input wire logic [7:0] port3_output_mode,
  output plsc_pkg::plsc_pin_drv_t port3_drv,
  output plsc_pkg::plsc_pin_drv_t port4_drv,
  output logic [7:0] port2_skip_out,
  output logic [7:0] port3_skip_out,
  output logic [7:0] port4_skip_out
);
  import plsc_pkg::*;

  typedef struct packed {
    logic [7:0] p2_skip;
    plsc_port_cfg_t port3;
    plsc_port_cfg_t port4;
    logic [7:0] rdata;
    logic hit;
    plsc_pin_drv_t d3;
    plsc_pin_drv_t d4;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] s4;
  } plsc_state_t;

  plsc_state_t st_q;
  plsc_state_t st_d;

  // package-dependent pin presence
  // presence is fixed at build time, so absent pins cost no run-time logic
  localparam logic [7:0] PORT3_PRESENT = LARGE_PKG ? PLSC_ALL_MASK : PLSC_PORT3_SMALL_MASK;
  localparam logic [7:0] PORT4_PRESENT = LARGE_PKG ? PLSC_ALL_MASK : PLSC_ZERO;

  // address match helper used by the write decode; the read decode uses a case on the address
  function automatic logic plsc_sel(input plsc_sfr_req_t r, input logic [7:0] a);
    plsc_sel = (r.addr == a);
  endfunction

  // per-port configuration as the pin logic sees it
  plsc_port_cfg_t port3_cfg;
  plsc_port_cfg_t port4_cfg;
  plsc_pin_drv_t d3_c;
  plsc_pin_drv_t d4_c;
  logic [7:0] rd3;
  logic [7:0] rd4;
  logic [7:0] sk3;
  logic [7:0] sk4;

  // third port's output mode lives elsewhere and comes in as a level
  // the stored third-port output mode is never used; the input replaces it
  always_comb begin
    port3_cfg = st_q.port3;
    port3_cfg.outmode = port3_output_mode;
    port4_cfg = st_q.port4;
  end

  // third port: pin drive, read-back and skip forcing
  plsc_pin_ctrl u_port3 (
    .cfg(port3_cfg),
    .present(PORT3_PRESENT),
    .pin_in(port3_pin_in),
    .drv(d3_c),
    .rd_val(rd3),
    .skip_out(sk3)
  );

  // fourth port: same logic, all pins absent in the small package
  plsc_pin_ctrl u_port4 (
    .cfg(port4_cfg),
    .present(PORT4_PRESENT),
    .pin_in(port4_pin_in),
    .drv(d4_c),
    .rd_val(rd4),
    .skip_out(sk4)
  );

  // next state: register writes, read mux, registered pin and crossbar outputs
  always_comb begin
    st_d = st_q;
    if (sfr_req.wr) begin
      // absent third-port bits are stored as written; the pin logic masks them, but input-mode and skip reads return them
      // second port has only its skip register in this block
      if (plsc_sel(sfr_req, PLSC_ADDR_PORT2_SKIP)) begin
        st_d.p2_skip = sfr_req.wdata;
      end
      // third port latch, input mode and skip
      if (plsc_sel(sfr_req, PLSC_ADDR_PORT3_LATCH)) begin
        st_d.port3.latch = sfr_req.wdata;
      end
      if (plsc_sel(sfr_req, PLSC_ADDR_PORT3_INMODE)) begin
        st_d.port3.inmode = sfr_req.wdata;
      end
      if (plsc_sel(sfr_req, PLSC_ADDR_PORT3_SKIP)) begin
        st_d.port3.skip = sfr_req.wdata;
      end
      // fourth port writes are dropped in the small package
      if (LARGE_PKG) begin
        if (plsc_sel(sfr_req, PLSC_ADDR_PORT4_LATCH)) begin
          st_d.port4.latch = sfr_req.wdata;
        end
        if (plsc_sel(sfr_req, PLSC_ADDR_PORT4_INMODE)) begin
          st_d.port4.inmode = sfr_req.wdata;
        end
        if (plsc_sel(sfr_req, PLSC_ADDR_PORT4_OUTMODE)) begin
          st_d.port4.outmode = sfr_req.wdata;
        end
      end
    end
    // read data: latch addresses return pins, config returns stored value, fourth port config reads zero in the small package
    st_d.hit = 1'b0;
    st_d.rdata = PLSC_ZERO;
    if (sfr_req.rd) begin
      st_d.hit = 1'b1;
      case (sfr_req.addr)
        PLSC_ADDR_PORT2_SKIP: st_d.rdata = st_q.p2_skip;
        PLSC_ADDR_PORT3_LATCH: st_d.rdata = rd3;
        PLSC_ADDR_PORT3_INMODE: st_d.rdata = st_q.port3.inmode;
        PLSC_ADDR_PORT3_SKIP: st_d.rdata = st_q.port3.skip;
        PLSC_ADDR_PORT4_LATCH: st_d.rdata = rd4;
        PLSC_ADDR_PORT4_INMODE: st_d.rdata = LARGE_PKG ? st_q.port4.inmode : PLSC_ZERO;
        PLSC_ADDR_PORT4_OUTMODE: st_d.rdata = LARGE_PKG ? st_q.port4.outmode : PLSC_ZERO;
        default: st_d.hit = 1'b0;
      endcase
    end
    st_d.d3 = d3_c;
    st_d.d4 = d4_c;
    // crossbar sees every port's skip set, absent pins forced skipped
    st_d.s2 = st_q.p2_skip;
    st_d.s3 = sk3;
    st_d.s4 = sk4;
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.p2_skip <= PLSC_RST_SKIP;
      st_q.port3.latch <= PLSC_RST_LATCH;
      st_q.port3.inmode <= PLSC_RST_INMODE;
      st_q.port3.outmode <= PLSC_RST_OUTMODE;
      st_q.port3.skip <= PLSC_RST_SKIP;
      st_q.port4.latch <= PLSC_RST_LATCH;
      st_q.port4.inmode <= PLSC_RST_INMODE;
      st_q.port4.outmode <= PLSC_RST_OUTMODE;
      st_q.port4.skip <= PLSC_RST_SKIP;
      // all pins released in reset so nothing fights the board at power-up
      st_q.d3.oe_n <= PLSC_ALL_MASK;
      st_q.d4.oe_n <= PLSC_ALL_MASK;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata = st_q.rdata;
  assign sfr_hit = st_q.hit;
  assign port3_drv = st_q.d3;
  assign port4_drv = st_q.d4;
  assign port2_skip_out = st_q.s2;
  assign port3_skip_out = st_q.s3;
  assign port4_skip_out = st_q.s4;
endmodule

// >>> plsc_port_regs_assertions.sv
// checker for the port register block, bound from the testbench
// assumes the large-package build and one clock domain
`timescale 1ns/10ps
module plsc_port_regs_assertions
  import plsc_pkg::*;
(
  input logic clk,
  input logic reset,
  input logic clk_en,
  input plsc_pkg::plsc_sfr_req_t sfr_req,
  input logic [7:0] sfr_rdata,
  input logic sfr_hit,
  input logic [7:0] port3_pin_in,
  input logic [7:0] port3_output_mode,
  input plsc_pkg::plsc_pin_drv_t port3_drv,
  input logic [7:0] port2_skip_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // config reaches the pins one enabled edge after it is stored
  sequence wr_at(logic [7:0] a);
    clk_en && sfr_req.wr && sfr_req.addr == a ##1 clk_en;
  endsequence
  sequence rd_at(logic [7:0] a);
    clk_en && sfr_req.rd && sfr_req.addr == a;
  endsequence
  port3_drive_a: assert property (wr_at(PLSC_ADDR_PORT3_LATCH) |=>
    ((port3_drv.dout ^ $past(sfr_req.wdata, 2)) & ~port3_drv.oe_n) == 8'h00) else $error("drv");
  p2_skip_a: assert property (wr_at(PLSC_ADDR_PORT2_SKIP) |=>
    port2_skip_out == $past(sfr_req.wdata, 2)) else $error("skip");
  analog_off_a: assert property ((port3_drv.ana & ~port3_drv.oe_n) == 8'h00)
    else $error("ana driven");
  open_drain_a: assert property ($stable(port3_output_mode) |->
    (port3_drv.dout & ~port3_drv.oe_n & ~port3_output_mode) == 8'h00) else $error("od");
  // a write just before the read would race the analog flag, so it is left out
  port3_read_a: assert property (rd_at(PLSC_ADDR_PORT3_LATCH) ##0 !$past(sfr_req.wr) |=>
    sfr_rdata == ($past(port3_pin_in) & ~$past(port3_drv.ana))) else $error("read");
  skip_hit_a: assert property (rd_at(PLSC_ADDR_PORT3_SKIP) |=> sfr_hit)
    else $error("hit");
  skip_cause_a: assert property ($changed(port2_skip_out) |->
    $past(sfr_req.wr, 2) && $past(sfr_req.addr, 2) == PLSC_ADDR_PORT2_SKIP) else $error("cause");
  hold_frozen_a: assert property (!clk_en |=> $stable(port3_drv) && $stable(port2_skip_out))
    else $error("frozen");
endmodule

// >>> testbench.sv
// bench for the port register block with the pin model on its far side
// assumes the default large-package build; inputs change at falling edges
`timescale 1ns/10ps
module testbench;
  import plsc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  plsc_sfr_req_t req = '0;
  logic [7:0] om3 = 8'h00;
  logic [7:0] rdata, p2s, p3s, p4s, pin3, pin4;
  logic hit;
  plsc_pin_drv_t d3, d4;
  int error_cnt = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  plsc_port_regs u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .sfr_req(req),
    .sfr_rdata(rdata), .sfr_hit(hit), .port3_pin_in(pin3), .port4_pin_in(pin4),
    .port3_output_mode(om3), .port3_drv(d3), .port4_drv(d4), .port2_skip_out(p2s),
    .port3_skip_out(p3s), .port4_skip_out(p4s));
  plsc_pin_model u_pins (.port3_drv(d3), .port4_drv(d4), .ext3(8'h5a), .ext4(8'h0f),
    .port3_pin_in(pin3), .port4_pin_in(pin4));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one bus cycle; strobes stay up until the next call, so back-to-back is clean
  task automatic op(input logic [1:0] wr_rd, input logic [7:0] a, input logic [7:0] d);
    req = '{wr: wr_rd[1], rd: wr_rd[0], addr: a, wdata: d};
    @(negedge clk);
  endtask
  // write, then one idle cycle so the pin outputs have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(2'h2, a, d);
    op(2'h0, 8'h00, 8'h00);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    op(2'h1, a, 8'h00);
    chk(rdata, exp);
    chk({7'h00, hit}, {7'h00, a != 8'h00});
    op(2'h0, 8'h00, 8'h00);
  endtask
  task automatic t_drive;
    chk(d3.oe_n, 8'hff);
    rd_chk(8'hb0, 8'h5a);
    om3 = 8'hff;
    wr(8'hb0, 8'ha5);
    chk(d3.oe_n, 8'h00);
    chk(d3.dout, 8'ha5);
    rd_chk(8'hb0, 8'ha5);
    om3 = 8'h0f;
    repeat (2) @(negedge clk);
    chk(d3.oe_n, 8'ha0);
  endtask
  task automatic t_analog;
    wr(8'hf4, 8'h0f);
    chk(d3.ana, 8'hf0);
    chk(d3.oe_n & 8'hf0, 8'hf0);
    rd_chk(8'hb0, 8'h05);
  endtask
  // analog pins get skipped too; an unmapped write in between must change nothing
  task automatic t_skip;
    chk(p2s, 8'h00);
    op(2'h2, 8'hd6, 8'h81);
    op(2'h2, 8'hdf, 8'hf0);
    wr(8'h00, 8'h77);
    chk(p2s, 8'h81);
    chk(p3s, 8'hf0);
    rd_chk(8'hdf, 8'hf0);
    rd_chk(8'h00, 8'h00);
    clk_en = 1'b0;
    wr(8'hd6, 8'h00);
    clk_en = 1'b1;
    @(negedge clk);
    chk(p2s, 8'h81);
  endtask
  task automatic t_port4;
    wr(8'hae, 8'hff);
    wr(8'hc7, 8'h3c);
    chk(d4.oe_n, 8'h00);
    chk(p4s, 8'h00);
    rd_chk(8'hc7, 8'h3c);
    wr(8'hf5, 8'h0f);
    chk(d4.ana, 8'hf0);
    chk(d4.oe_n, 8'hf0);
    rd_chk(8'hc7, 8'h0c);
    rd_chk(8'hae, 8'hff);
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_drive();
    t_analog();
    t_skip();
    t_port4();
    report_and_stop();
  end
endmodule
bind plsc_port_regs plsc_port_regs_assertions u_chk (.clk(clk), .reset(reset), .clk_en(clk_en),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .port3_pin_in(port3_pin_in),
  .port3_output_mode(port3_output_mode), .port3_drv(port3_drv), .port2_skip_out(port2_skip_out));
